// ==== core/srd_decode.sv ====
// stack, carry-clear, return and rotate opcode decoder
`timescale 1ns/10ps
module srd_decode
  import srd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] data_in,
  input wire logic [15:0] ret_addr,
  output logic busy,
  output logic done,
  output logic handled,
  output logic pass_valid,
  output logic [7:0] pass_opcode,
  output logic [2:0] fetch_cycles,
  output logic [2:0] exec_cycles,
  output logic indirect,
  output logic wide,
  output logic [7:0] flags,
  output logic [7:0] sp,
  output logic [15:0] pc,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic [7:0] result,
  output logic operand_bad
);
  srd_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] arg_reg, arg_next;
  logic [7:0] dat_reg, dat_next;
  logic [15:0] ret_reg, ret_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] sp_reg, sp_next;
  logic [15:0] pc_reg, pc_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic handled_reg, handled_next;
  logic pass_reg, pass_next;
  logic [7:0] pass_op_reg, pass_op_next;
  logic [2:0] fc_reg, fc_next;
  logic [2:0] ec_reg, ec_next;
  logic ind_reg, ind_next;
  logic wide_reg, wide_next;
  logic we_reg, we_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] res_reg, res_next;
  logic bad_reg, bad_next;

  // decode of the incoming opcode
  logic known;
  logic dec_ind;
  logic dec_wide;
  logic [2:0] dec_fc;
  logic [2:0] dec_ec;
  srd_rot_t dec_rot;
  srd_rot_t ex_rot;
  logic [7:0] rot_out;
  logic rot_c, rot_z, rot_s, rot_v;

  always_comb begin
    known = 1'b1;
    dec_ind = opcode[0];
    dec_wide = 1'b0;
    dec_rot = SRD_ROT_NONE;
    dec_fc = CYC_TWO;
    dec_ec = opcode[0] ? CYC_THREE : CYC_TWO;
    case (opcode)
      OP_PULL_R, OP_PULL_IR, OP_STORE_R, OP_STORE_IR: begin
      end
      OP_PULL_WIDE, OP_STORE_WIDE: begin
        dec_wide = 1'b1;
        dec_ind = 1'b0;
        dec_fc = CYC_THREE;
        dec_ec = CYC_TWO;
      end
      OP_CARRY_CLEAR: begin
        dec_ind = 1'b0;
        dec_fc = CYC_ONE;
        dec_ec = CYC_TWO;
      end
      OP_SUB_EXIT: begin
        dec_ind = 1'b0;
        dec_fc = CYC_ONE;
        dec_ec = CYC_FOUR;
      end
      OP_ROT_L_R, OP_ROT_L_IR: dec_rot = SRD_ROT_L;
      OP_ROT_LC_R, OP_ROT_LC_IR: dec_rot = SRD_ROT_LC;
      OP_ROT_R_R, OP_ROT_R_IR: dec_rot = SRD_ROT_R;
      OP_ROT_RC_R, OP_ROT_RC_IR: dec_rot = SRD_ROT_RC;
      default: begin
        known = 1'b0;
        dec_ind = 1'b0;
        dec_fc = 3'h0;
        dec_ec = 3'h0;
      end
    endcase
  end

  always_comb begin
    case (op_reg)
      OP_ROT_L_R, OP_ROT_L_IR: ex_rot = SRD_ROT_L;
      OP_ROT_LC_R, OP_ROT_LC_IR: ex_rot = SRD_ROT_LC;
      OP_ROT_R_R, OP_ROT_R_IR: ex_rot = SRD_ROT_R;
      OP_ROT_RC_R, OP_ROT_RC_IR: ex_rot = SRD_ROT_RC;
      default: ex_rot = SRD_ROT_NONE;
    endcase
  end

  srd_rotator u_rot (
    .kind(ex_rot),
    .din(dat_reg),
    .cin(flags_reg[FLAG_C]),
    .dout(rot_out),
    .cout(rot_c),
    .zero(rot_z),
    .sign(rot_s),
    .ovf(rot_v)
  );

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    arg_next = arg_reg;
    dat_next = dat_reg;
    ret_next = ret_reg;
    flags_next = flags_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    handled_next = handled_reg;
    pass_next = 1'b0;
    pass_op_next = pass_op_reg;
    fc_next = fc_reg;
    ec_next = ec_reg;
    ind_next = ind_reg;
    wide_next = wide_reg;
    we_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    res_next = res_reg;
    bad_next = bad_reg;
    case (state_reg)
      SRD_ST_IDLE: begin
        if (op_valid) begin
          if (known) begin
            state_next = SRD_ST_EXEC;
            cnt_next = dec_ec - 3'h1;
            op_next = opcode;
            // operand byte kept whole, field split is left downstream
            arg_next = operand;
            dat_next = data_in;
            ret_next = ret_addr;
            busy_next = 1'b1;
            handled_next = 1'b1;
            fc_next = dec_fc;
            ec_next = dec_ec;
            ind_next = dec_ind;
            wide_next = dec_wide;
            // pair operands must be even, full pairs top out at FE; decoded opcodes clear operand_bad without checking the operand
            bad_next = 1'b0;
          end else begin
            state_next = SRD_ST_PASS;
            pass_next = 1'b1;
            pass_op_next = opcode;
            handled_next = 1'b0;
            fc_next = 3'h0;
            ec_next = 3'h0;
            bad_next = (opcode[3:0] == 4'hC) && operand[0];
          end
        end
      end
      SRD_ST_EXEC: begin
        cnt_next = cnt_reg - 3'h1;
        if (cnt_reg == 3'h1) begin
          state_next = SRD_ST_DONE;
          case (op_reg)
            OP_PULL_R, OP_PULL_IR, OP_PULL_WIDE: begin
              addr_next = sp_reg;
              res_next = dat_reg;
              sp_next = sp_reg + SP_STEP;
            end
            OP_STORE_R, OP_STORE_IR, OP_STORE_WIDE: begin
              sp_next = sp_reg - SP_STEP;
              addr_next = sp_reg - SP_STEP;
              wdata_next = dat_reg;
              we_next = 1'b1;
            end
            OP_CARRY_CLEAR: flags_next[FLAG_C] = 1'b0;
            OP_SUB_EXIT: begin
              pc_next = ret_reg;
              addr_next = sp_reg;
              sp_next = sp_reg + SP_STEP_EXIT;
            end
            default: begin
              res_next = rot_out;
              flags_next[FLAG_C] = rot_c;
              flags_next[FLAG_Z] = rot_z;
              flags_next[FLAG_S] = rot_s;
              flags_next[FLAG_V] = rot_v;
            end
          endcase
        end
      end
      SRD_ST_DONE: begin
        state_next = SRD_ST_IDLE;
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      SRD_ST_PASS: state_next = SRD_ST_IDLE;
      default: state_next = SRD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SRD_ST_IDLE;
      cnt_reg <= 3'h0;
      op_reg <= 8'h00;
      arg_reg <= 8'h00;
      dat_reg <= 8'h00;
      ret_reg <= 16'h0000;
      flags_reg <= FLAGS_RESET;
      sp_reg <= SP_RESET;
      pc_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      handled_reg <= 1'b0;
      pass_reg <= 1'b0;
      pass_op_reg <= 8'h00;
      fc_reg <= 3'h0;
      ec_reg <= 3'h0;
      ind_reg <= 1'b0;
      wide_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      res_reg <= 8'h00;
      bad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      arg_reg <= arg_next;
      dat_reg <= dat_next;
      ret_reg <= ret_next;
      flags_reg <= flags_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      handled_reg <= handled_next;
      pass_reg <= pass_next;
      pass_op_reg <= pass_op_next;
      fc_reg <= fc_next;
      ec_reg <= ec_next;
      ind_reg <= ind_next;
      wide_reg <= wide_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      res_reg <= res_next;
      bad_reg <= bad_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign handled = handled_reg;
  assign pass_valid = pass_reg;
  assign pass_opcode = pass_op_reg;
  assign fetch_cycles = fc_reg;
  assign exec_cycles = ec_reg;
  assign indirect = ind_reg;
  assign wide = wide_reg;
  assign flags = flags_reg;
  assign sp = sp_reg;
  assign pc = pc_reg;
  assign mem_we = we_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign result = res_reg;
  assign operand_bad = bad_reg;

  // assertions
  pull_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_PULL_R) |=> sp_reg == $past(sp_reg) + SP_STEP)
    else $error("pull did not raise stack pointer by one");
  store_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_STORE_R) |=> mem_we && sp_reg == mem_addr)
    else $error("store did not write at lowered pointer");
  exit_sp_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_SUB_EXIT) |=> sp_reg == $past(sp_reg) + SP_STEP_EXIT)
    else $error("return did not add two to stack pointer");
  carry_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_CARRY_CLEAR)
      |=> !flags_reg[FLAG_C] && flags_reg[6:0] == $past(flags_reg[6:0]))
    else $error("carry clear wrong");
  exit_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_IDLE && op_valid && opcode == OP_SUB_EXIT) |=> ##4 done)
    else $error("return execution not four cycles");
  ind_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_IDLE && op_valid && opcode == OP_ROT_L_IR) |=> exec_cycles == CYC_THREE ##3 done)
    else $error("indirect rotate timing wrong");
  wide_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_IDLE && op_valid && opcode == OP_PULL_WIDE) |=> fetch_cycles == CYC_THREE && wide)
    else $error("wide pull fetch count wrong");
  rot_dh_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && ex_rot != SRD_ROT_NONE) |=> $stable(flags_reg[FLAG_D]) && $stable(flags_reg[FLAG_H]))
    else $error("rotate touched D or H");
  pass_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_IDLE && op_valid && !known) |=> pass_valid && $stable(sp_reg) && $stable(flags_reg))
    else $error("unknown opcode disturbed state");
  done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    done |=> !done)
    else $error("done held longer than one cycle");
  wide_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_PULL_WIDE)
      |=> sp_reg == $past(sp_reg) + SP_STEP)
    else $error("wide pull did not raise stack pointer by one");
  wide_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_STORE_WIDE)
      |=> mem_we && sp_reg == mem_addr)
    else $error("wide store did not write at lowered pointer");
  pull_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && op_reg == OP_PULL_IR) |=> $stable(flags_reg))
    else $error("pull changed the flags");
  exit_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && op_reg == OP_SUB_EXIT) |=> pc == ret_reg)
    else $error("return did not load program counter");
  // source byte stays put through the done cycle, so it is still comparable
  rot_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_EXEC && cnt_reg == 3'h1 && ex_rot == SRD_ROT_R)
      |=> flags_reg[FLAG_C] == dat_reg[0] && result == {dat_reg[0], dat_reg[7:1]})
    else $error("rotate right end bit wrong");
  pair_odd_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == SRD_ST_IDLE && op_valid && !known && opcode[3:0] == 4'hC && operand[0])
      |=> operand_bad)
    else $error("odd pair operand not flagged");
  cov_store_c: cover property (@(posedge clk) disable iff (!rst_n) mem_we);
  cov_pull_c: cover property (@(posedge clk) disable iff (!rst_n) done && op_reg == OP_PULL_WIDE);
  cov_rot_c: cover property (@(posedge clk) disable iff (!rst_n) done && op_reg == OP_ROT_RC_IR);
  cov_pass_c: cover property (@(posedge clk) disable iff (!rst_n) pass_valid);
endmodule // srd_decode

// ==== core/srd_pkg.sv ====
// constants and types for the stack and rotate opcode decoder
// Notes on behaviour
// - bit operand is three bits, zero to seven
// - working register operand picks one of sixteen
// - register pair operand is even, zero to fourteen
// - register operand is eight-bit address 00..FF
// - full register pair address is even, 00..FE
// - extended register twelve bits, direct address sixteen
// - relative offset signed byte from next instruction
// - polarity bit picks cleared or set test
// - vector operand is eight bits 00..FF
// - pull 50/51 loads then increments stack pointer
// - wide pull D8, three fetch, two execute
// - store 70/71 decrements then writes stack
// - wide store C8, three fetch, two execute
// - carry clear CF zeroes carry, 1/2 cycles
// - exit AF pops program counter, adds two
// - rotate left via carry 10/11 sets C Z S V
// - rotate right via carry C0/C1 sets C Z S V
package srd_pkg;
  localparam logic [7:0] OP_PULL_R = 8'h50;
  localparam logic [7:0] OP_PULL_IR = 8'h51;
  localparam logic [7:0] OP_PULL_WIDE = 8'hD8;
  localparam logic [7:0] OP_STORE_R = 8'h70;
  localparam logic [7:0] OP_STORE_IR = 8'h71;
  localparam logic [7:0] OP_STORE_WIDE = 8'hC8;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hCF;
  localparam logic [7:0] OP_SUB_EXIT = 8'hAF;
  localparam logic [7:0] OP_ROT_L_R = 8'h90;
  localparam logic [7:0] OP_ROT_L_IR = 8'h91;
  localparam logic [7:0] OP_ROT_LC_R = 8'h10;
  localparam logic [7:0] OP_ROT_LC_IR = 8'h11;
  localparam logic [7:0] OP_ROT_R_R = 8'hE0;
  localparam logic [7:0] OP_ROT_R_IR = 8'hE1;
  localparam logic [7:0] OP_ROT_RC_R = 8'hC0;
  localparam logic [7:0] OP_ROT_RC_IR = 8'hC1;
  // flag field positions in the flag byte
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] PAIR_MAX = 8'hFE;
  localparam logic [3:0] WPAIR_MAX = 4'hE;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] SP_STEP_EXIT = 8'h02;
  typedef enum logic [3:0] {
    SRD_ST_IDLE = 4'b0001,
    SRD_ST_EXEC = 4'b0010,
    SRD_ST_DONE = 4'b0100,
    SRD_ST_PASS = 4'b1000
  } srd_state_t;
  typedef enum logic [2:0] {
    SRD_ROT_NONE = 3'h0,
    SRD_ROT_L = 3'h1,
    SRD_ROT_LC = 3'h2,
    SRD_ROT_R = 3'h3,
    SRD_ROT_RC = 3'h4
  } srd_rot_t;
endpackage

// ==== core/srd_rotator.sv ====
// byte rotator with carry, plain or through carry
`timescale 1ns/10ps
module srd_rotator
  import srd_pkg::*;
(
  input wire srd_rot_t kind,
  input wire logic [7:0] din,
  input wire logic cin,
  output logic [7:0] dout,
  output logic cout,
  output logic zero,
  output logic sign,
  output logic ovf
);
  always_comb begin
    dout = din;
    cout = cin;
    case (kind)
      SRD_ROT_L: begin
        dout = {din[6:0], din[7]};
        cout = din[7];
      end
      SRD_ROT_LC: begin
        dout = {din[6:0], cin};
        cout = din[7];
      end
      SRD_ROT_R: begin
        dout = {din[0], din[7:1]};
        cout = din[0];
      end
      SRD_ROT_RC: begin
        dout = {cin, din[7:1]};
        cout = din[0];
      end
      default: begin
        dout = din;
        cout = cin;
      end
    endcase
    zero = (dout == 8'h00);
    sign = dout[7];
    // overflow marks a change of sign across the rotate
    ovf = dout[7] ^ din[7];
  end
endmodule // srd_rotator

// ==== test/srd_decode_tb.sv ====
// self-checking bench for the stack, carry-clear, return and rotate decoder
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module srd_decode_tb;
  import srd_pkg::*;
  typedef struct {
    logic pass;
    logic [7:0] op;
    logic [2:0] fc;
    logic [2:0] ec;
    logic ind;
    logic wd;
    logic [7:0] fl;
    logic [7:0] sp;
    logic [15:0] pc;
    logic chk_res;
    logic [7:0] res;
    logic st;
    logic [7:0] wdat;
    logic bad;
  } srd_note_t;
  localparam logic [7:0] OPS [16] = '{8'h50, 8'h51, 8'hD8, 8'h70, 8'h71, 8'hC8, 8'hCF, 8'hAF,
                                      8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1};
  logic clk;
  logic rst_n;
  logic op_valid;
  logic [7:0] opcode;
  logic [7:0] operand;
  logic [7:0] data_in;
  logic [15:0] ret_addr;
  logic busy;
  logic done;
  logic handled;
  logic pass_valid;
  logic [7:0] pass_opcode;
  logic [2:0] fetch_cycles;
  logic [2:0] exec_cycles;
  logic indirect;
  logic wide;
  logic [7:0] flags;
  logic [7:0] sp;
  logic [15:0] pc;
  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] result;
  logic operand_bad;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0 = 0;
  int n_we = 0;
  int tmo = 0;
  logic [7:0] m_fl = FLAGS_RESET;
  logic [7:0] m_sp = SP_RESET;
  logic [15:0] m_pc = 16'h0000;
  srd_note_t q[$];
  srd_note_t e;

  srd_decode dut_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode), .operand(operand),
    .data_in(data_in), .ret_addr(ret_addr), .busy(busy), .done(done), .handled(handled),
    .pass_valid(pass_valid), .pass_opcode(pass_opcode), .fetch_cycles(fetch_cycles),
    .exec_cycles(exec_cycles), .indirect(indirect), .wide(wide), .flags(flags), .sp(sp), .pc(pc),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .result(result), .operand_bad(operand_bad));

  always #5 clk = ~clk;

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // model the instruction, note the expectation, then drive it
  task automatic issue(input logic [7:0] op);
    srd_note_t n;
    logic [7:0] d;
    logic [7:0] r;
    logic [15:0] ra;
    logic [7:0] o;
    logic c;
    logic rot;
    int k;
    d = 8'($urandom);
    ra = 16'($urandom);
    o = 8'($urandom);
    rot = 1'b1;
    n = '{default: '0};
    n.op = op;
    n.fl = m_fl;
    n.sp = m_sp;
    n.pc = m_pc;
    case (op)
      OP_ROT_L_R, OP_ROT_L_IR: r = {d[6:0], d[7]};
      OP_ROT_LC_R, OP_ROT_LC_IR: r = {d[6:0], m_fl[FLAG_C]};
      OP_ROT_R_R, OP_ROT_R_IR: r = {d[0], d[7:1]};
      OP_ROT_RC_R, OP_ROT_RC_IR: r = {m_fl[FLAG_C], d[7:1]};
      default: rot = 1'b0;
    endcase
    c = (op == OP_ROT_L_R || op == OP_ROT_L_IR || op == OP_ROT_LC_R || op == OP_ROT_LC_IR) ? d[7] : d[0];
    if (rot) begin
      n.res = r;
      n.chk_res = 1'b1;
      n.fl[FLAG_C] = c;
      n.fl[FLAG_Z] = (r == 8'h00);
      n.fl[FLAG_S] = r[7];
      n.fl[FLAG_V] = r[7] ^ d[7];
    end
    case (op)
      OP_PULL_R, OP_PULL_IR, OP_PULL_WIDE: begin
        n.sp = m_sp + SP_STEP;
        n.chk_res = 1'b1;
        n.res = d;
      end
      OP_STORE_R, OP_STORE_IR, OP_STORE_WIDE: begin
        n.sp = m_sp - SP_STEP;
        n.st = 1'b1;
        n.wdat = d;
      end
      OP_CARRY_CLEAR: n.fl[FLAG_C] = 1'b0;
      OP_SUB_EXIT: begin
        n.pc = ra;
        n.sp = m_sp + SP_STEP_EXIT;
      end
      default: n.pass = !rot;
    endcase
    n.bad = n.pass && (op[3:0] == 4'hC) && o[0];
    if (!n.pass) begin
      n.wd = (op == OP_PULL_WIDE || op == OP_STORE_WIDE);
      n.ind = op[0] && !n.wd && op != OP_CARRY_CLEAR && op != OP_SUB_EXIT;
      n.fc = n.wd ? 3'h3 : (op == OP_CARRY_CLEAR || op == OP_SUB_EXIT) ? 3'h1 : 3'h2;
      n.ec = (op == OP_SUB_EXIT) ? 3'h4 : n.ind ? 3'h3 : 3'h2;
    end
    m_fl = n.fl;
    m_sp = n.sp;
    m_pc = n.pc;
    q.push_back(n);
    @(posedge clk);
    op_valid <= 1'b1;
    opcode <= op;
    operand <= o;
    data_in <= d;
    ret_addr <= ra;
    @(posedge clk);
    op_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!(done === 1'b1 || pass_valid === 1'b1) && k < 20);
    if (k >= 20) begin
      n_errors++;
      $display("[ERR] completion exp 1 got 0");
    end
    if (pass_valid === 1'b1)
      repeat (2) @(posedge clk);
  endtask

  // result watcher: oldest note against each done or pass pulse
  always @(posedge clk) begin
    cyc++;
    if (rst_n === 1'b1) begin
      if (op_valid === 1'b1 && busy === 1'b0)
        t0 = cyc;
      if (mem_we === 1'b1)
        n_we++;
      if (mem_we === 1'b1) begin
        `CHK("mem_addr", q[0].sp, mem_addr)
        `CHK("busy at write", 1'b1, busy)
        `CHK("mem_wdata", q[0].wdat, mem_wdata)
      end
      if (done === 1'b1 || pass_valid === 1'b1) begin
        e = q.pop_front();
        `CHK("pass_valid", e.pass, pass_valid)
        `CHK("latency", (e.pass ? 1 : int'(e.ec) + 1), cyc - t0)
        `CHK("busy", 1'b0, busy)
        `CHK("operand_bad", e.bad, operand_bad)
        `CHK("fetch_cycles", e.fc, fetch_cycles)
        `CHK("exec_cycles", e.ec, exec_cycles)
        `CHK("flags", e.fl, flags)
        `CHK("sp", e.sp, sp)
        `CHK("pc", e.pc, pc)
        `CHK("mem_we count", int'(e.st), n_we)
        if (e.pass) begin
          `CHK("pass_opcode", e.op, pass_opcode)
          `CHK("handled", 1'b0, handled)
        end else begin
          `CHK("handled", 1'b1, handled)
          `CHK("indirect", e.ind, indirect)
          `CHK("wide", e.wd, wide)
        end
        if (e.chk_res)
          `CHK("result", e.res, result)
        n_we = 0;
      end
    end
  end

  // hang guard, far above the ~550 cycles the run needs
  always @(posedge clk) begin
    tmo++;
    if (tmo == 5000) begin
      n_errors++;
      $display("[ERR] timeout exp 0 got 1");
      end_sim();
    end
  end

  initial begin
    logic [7:0] u;
    clk = 1'b0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    opcode = 8'h00;
    operand = 8'h00;
    data_in = 8'h00;
    ret_addr = 16'h0000;
    void'($urandom(32'hF51CECDC));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("sp reset", SP_RESET, sp)
    `CHK("flags reset", FLAGS_RESET, flags)
    `CHK("busy reset", 1'b0, busy)
    // first store wraps the pointer below zero
    foreach (OPS[i])
      issue(OPS[(i + 3) % 16]);
    repeat (80) begin
      if ($urandom_range(0, 4) == 0) begin
        do u = 8'($urandom); while (u inside {OPS});
        // no decoded opcode ends in C, so this stays a pass-through
        if ($urandom_range(0, 1) == 1)
          u[3:0] = 4'hC;
        issue(u);
      end else begin
        issue(OPS[$urandom_range(0, 15)]);
      end
    end
    repeat (4) @(posedge clk);
    `CHK("queue empty", 0, q.size())
    end_sim();
  end
endmodule // srd_decode_tb
